// file: rtl/crc_pkg.sv
// Purpose: shared constants and types for the byte-fed CRC16 generator
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: register offsets are byte addresses
package crc_pkg;

    // ----------------------------------------
    // Bus widths
    // ----------------------------------------
    localparam int CRC_ADDR_W = 12;
    localparam int CRC_DATA_W = 32;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [CRC_ADDR_W-1:0] CRC_OFF_HIGH = 12'h000;
    localparam logic [CRC_ADDR_W-1:0] CRC_OFF_LOW = 12'h004;

    // ----------------------------------------
    // Generator constants
    // ----------------------------------------
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_REM_RESET = 16'h0000;
    localparam int CRC_BYTE_BITS = 8;
    localparam logic [23:0] CRC_PAD_ZERO = 24'h000000;
    localparam logic [CRC_DATA_W-1:0] CRC_RDATA_RESET = 32'h00000000;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [CRC_ADDR_W-1:0] paddr;
        logic [CRC_DATA_W-1:0] pwdata;
    } crc_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [CRC_DATA_W-1:0] prdata;
    } crc_apb_rsp_t;

    typedef enum logic {
        CRC_RUN,
        CRC_SEED_LOW
    } crc_state_t;

endpackage

// file: rtl/crc_byte_gen.sv
// Purpose: CRC16 generator fed one byte at a time over APB
// Assumes: single clock, bus master follows the APB handshake
// Notes: answer comes one cycle into the access phase
//
// Summary of operation
// - High-byte write loads remainder bits 15-8 and arms the seed sequence.
// - Next low-byte write after high write loads bits 7-0, no shifting.
// - Later low-byte writes shift the data byte in, MSB first, eight bits.
// - Whole byte shifted by the next bus cycle; result then readable.
// - Low-byte read returns remainder bits 7-0 straight from shift register.
// - High and low reads together give the full 16-bit remainder.
// - CCITT CRC16 accumulates every data byte until a new seed.
// - High-byte write at any time restarts the seed sequence.
// - Low register is the low byte of the one 16-bit remainder.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/10ps

module crc_byte_gen
    import crc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB request and answer
    input wire crc_apb_req_t apb_req,
    output crc_apb_rsp_t apb_rsp,
    // Current remainder
    output logic [15:0] crc_value
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic reg_hit(input logic [CRC_ADDR_W-1:0] addr,
                                     input logic [CRC_ADDR_W-1:0] off);
        reg_hit = (addr == off);
    endfunction

    // one byte through the CCITT polynomial
    function automatic logic [15:0] crc_byte(input logic [15:0] rem_in,
                                             input logic [7:0] data);
        logic [15:0] r;
        logic fb;
        r = rem_in;
        fb = 1'b0;
        for (int i = CRC_BYTE_BITS - 1; i >= 0; i--) begin
            fb = data[i] ^ r[15];
            r = {r[14:0], 1'b0};
            if (fb) begin
                r = r ^ CRC_POLY;
            end
        end
        crc_byte = r;
    endfunction

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic hit_high;
    logic hit_low;
    logic mapped;
    logic acc_wait;
    logic acc_done;
    logic wr_high;
    logic wr_low;

    assign hit_high = reg_hit(apb_req.paddr, CRC_OFF_HIGH);
    assign hit_low = reg_hit(apb_req.paddr, CRC_OFF_LOW);
    assign mapped = hit_high | hit_low;
    assign acc_wait = apb_req.psel & apb_req.penable & ~apb_rsp.pready;
    // Writes land only on the edge where pready is sampled high
    assign acc_done = apb_req.psel & apb_req.penable & apb_rsp.pready;
    assign wr_high = acc_done & apb_req.pwrite & hit_high;
    assign wr_low = acc_done & apb_req.pwrite & hit_low;

    // ----------------------------------------
    // Remainder and seed state
    // ----------------------------------------
    crc_state_t state;
    crc_state_t next_state;
    logic [15:0] remainder;
    logic [15:0] next_remainder;

    always_comb begin
        next_state = state;
        next_remainder = remainder;
        if (wr_high) begin
            // high byte straight in, seed armed
            next_remainder = {apb_req.pwdata[7:0], remainder[7:0]};
            next_state = CRC_SEED_LOW;
        end else if (wr_low) begin
            case (state)
                CRC_SEED_LOW: begin
                    next_remainder = {remainder[15:8], apb_req.pwdata[7:0]};
                    next_state = CRC_RUN;
                end
                CRC_RUN: begin
                    // whole byte done in one clock
                    next_remainder = crc_byte(remainder, apb_req.pwdata[7:0]);
                end
                default: begin
                    next_state = CRC_RUN;
                end
            endcase
        end
    end

    // reset clears remainder and seed state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= CRC_RUN;
            remainder <= CRC_REM_RESET;
        end else begin
            state <= next_state;
            remainder <= next_remainder;
        end
    end

    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    crc_apb_rsp_t next_rsp;
    logic [15:0] next_value;

    always_comb begin
        next_rsp.pready = acc_wait;
        next_rsp.pslverr = acc_wait & ~mapped;
        next_rsp.prdata = CRC_RDATA_RESET;
        if (acc_wait & ~apb_req.pwrite) begin
            if (hit_high) begin
                next_rsp.prdata = {CRC_PAD_ZERO, remainder[15:8]};
            end else if (hit_low) begin
                // low byte straight from the shift register
                next_rsp.prdata = {CRC_PAD_ZERO, remainder[7:0]};
            end
        end
        next_value = next_remainder;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            apb_rsp <= '0;
            crc_value <= CRC_REM_RESET;
        end else begin
            apb_rsp <= next_rsp;
            crc_value <= next_value;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic rd_wait_high;
    logic rd_wait_low;
    assign rd_wait_high = acc_wait & ~apb_req.pwrite & hit_high;
    assign rd_wait_low = acc_wait & ~apb_req.pwrite & hit_low;

    sequence seq_access_wait;
        apb_req.psel && apb_req.penable && !apb_rsp.pready;
    endsequence

    sequence seq_answer;
        apb_rsp.pready ##1 !apb_rsp.pready;
    endsequence

    chk_high_loads_upper: assert property (
        wr_high |=> remainder[15:8] == $past(apb_req.pwdata[7:0])
            && state == CRC_SEED_LOW)
        else $error("high write did not load upper byte");

    chk_seed_low_direct: assert property (
        wr_low && state == CRC_SEED_LOW |=>
            remainder == {$past(remainder[15:8]), $past(apb_req.pwdata[7:0])}
            && state == CRC_RUN)
        else $error("seed low byte not loaded directly");

    chk_data_shifted: assert property (
        wr_low && state == CRC_RUN |=>
            remainder == crc_byte($past(remainder), $past(apb_req.pwdata[7:0])))
        else $error("data byte not shifted into remainder");

    chk_byte_done_next: assert property (
        wr_low && state == CRC_RUN |=>
            crc_value == crc_byte($past(remainder), $past(apb_req.pwdata[7:0])))
        else $error("result not ready one cycle after data write");

    chk_read_low_byte: assert property (
        rd_wait_low |=> apb_rsp.pready
            && apb_rsp.prdata == {CRC_PAD_ZERO, $past(remainder[7:0])})
        else $error("low read does not match remainder");

    chk_read_high_byte: assert property (
        rd_wait_high |=> apb_rsp.pready
            && apb_rsp.prdata == {CRC_PAD_ZERO, $past(remainder[15:8])})
        else $error("high read does not match remainder");

    chk_remainder_hold: assert property (
        !wr_high && !wr_low |=> $stable(remainder) && $stable(state))
        else $error("remainder changed without a write");

    chk_zero_data_step: assert property (
        wr_low && state == CRC_RUN && remainder == 16'h8000
            && apb_req.pwdata[7:0] == 8'h00 |=> remainder == 16'h9188)
        else $error("polynomial step gives wrong value");

    chk_answer_once: assert property (
        seq_access_wait |=> seq_answer)
        else $error("access not answered in one cycle");

    chk_unmapped_err: assert property (
        seq_access_wait and !mapped |=> apb_rsp.pslverr)
        else $error("unmapped access not flagged");

endmodule

// file: tb/crc_apb_host.sv
// Purpose: APB master standing in for the processor core
// Assumes: slave answers with pready after any latency
// Notes: a hang is cut short by the bench watchdog
`timescale 1ns/10ps

module crc_apb_host
    import crc_pkg::*;
(
    // Clock
    input wire logic clk,
    // Bus
    output crc_apb_req_t req,
    input wire crc_apb_rsp_t rsp
);
    initial req = '0;

    // seed then data order
    // Caller sequences writes; one transfer at a time
    task automatic xfer(input logic wr, input logic [CRC_ADDR_W-1:0] a,
                        input logic [7:0] d, output logic [CRC_DATA_W-1:0] rd,
                        output logic err);
        req <= '{1'b1, 1'b0, wr, a, {CRC_PAD_ZERO, d}};
        @(posedge clk);
        req.penable <= 1'b1;
        // Answer taken at the rising edge, as the slave sees it
        do @(posedge clk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        // Released lines must not keep showing the old value
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        req.paddr <= ~a;
        req.pwdata <= ~{CRC_PAD_ZERO, d};
        @(posedge clk);
    endtask
endmodule

// file: tb/crc_byte_gen_tb_top.sv
// Purpose: self-checking bench for crc_byte_gen
// Assumes: host model drives APB, 200 MHz clock
// Notes: expected remainders worked out by hand
`timescale 1ns/10ps

module crc_byte_gen_tb_top
    import crc_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    crc_apb_req_t req;
    crc_apb_rsp_t rsp;
    logic [15:0] crc_value;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int num_checks = 0;
    // Seed, data byte, remainder after it
    logic [15:0] rows [4][3] = '{'{16'h0000, 16'h0001, 16'h1021},
        '{16'h8000, 16'h0000, 16'h9188}, '{16'hFFFF, 16'h0000, 16'hE1F0},
        '{16'h1234, 16'h0012, 16'h3400}};

    always #2.5 clk = ~clk;

    crc_apb_host i_crc_apb_host (.clk(clk), .req(req), .rsp(rsp));
    crc_byte_gen i_crc_byte_gen (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
        .crc_value(crc_value));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        i_crc_apb_host.xfer(1'b1, a, d, rd, err);
    endtask

    task automatic rem(input logic [15:0] exp);
        i_crc_apb_host.xfer(1'b0, CRC_OFF_HIGH, 8'h00, rd, err);
        check("high read", {24'h000000, exp[15:8]}, rd);
        i_crc_apb_host.xfer(1'b0, CRC_OFF_LOW, 8'h00, rd, err);
        check("low read", {24'h000000, exp[7:0]}, rd);
        check("crc_value", {16'h0000, exp}, {16'h0000, crc_value});
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("crc_value after reset", 32'h00000000, {16'h0000, crc_value});
        wr(CRC_OFF_LOW, 8'h01);
        rem(16'h1021);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(CRC_OFF_HIGH, rows[i][0][15:8]);
            wr(CRC_OFF_LOW, rows[i][0][7:0]);
            rem(rows[i][0]);
            wr(CRC_OFF_LOW, rows[i][1][7:0]);
            rem(rows[i][2]);
            $display("test row %0d done", i);
        end
        // Check string back to back after an all-ones seed
        wr(CRC_OFF_HIGH, 8'hFF);
        wr(CRC_OFF_LOW, 8'hFF);
        for (int k = 1; k <= 9; k++) begin
            wr(CRC_OFF_LOW, 8'h30 + k[7:0]);
        end
        rem(16'h29B1);
        $display("test string done");
        // Restart mid-run, upper byte written twice before the low seed
        wr(CRC_OFF_HIGH, 8'h80);
        rem(16'h80B1);
        wr(CRC_OFF_HIGH, 8'h55);
        wr(CRC_OFF_LOW, 8'hAA);
        rem(16'h55AA);
        $display("test restart done");
        // Unmapped and unaligned places are refused and change nothing
        i_crc_apb_host.xfer(1'b1, 12'h008, 8'h11, rd, err);
        check("slverr write", 32'h00000001, {31'h00000000, err});
        i_crc_apb_host.xfer(1'b0, 12'h002, 8'h00, rd, err);
        check("slverr read", 32'h00000001, {31'h00000000, err});
        check("refused rdata", 32'h00000000, rd);
        rem(16'h55AA);
        $display("test unmapped done");
        // Reset while a seed is armed must drop the armed state
        wr(CRC_OFF_HIGH, 8'hC3);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        check("crc_value in reset", 32'h00000000, {16'h0000, crc_value});
        rst <= 1'b0;
        @(posedge clk);
        wr(CRC_OFF_LOW, 8'h01);
        rem(16'h1021);
        $display("test mid reset done");
        stop_test();
    end

    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        stop_test();
    end
endmodule
